//--- dsp_pkg.sv
/* Types, constants and pure helper functions of the fixed-point DSP core.
   Assumes one clock domain; memories sit outside the core. */
// Functional notes
// - Products accumulate into 40-bit accumulator; shifter normalizes
// - Every instruction except REP passes fetch, decode, execute in order; REP ends in decode
// - Words are fractions, 0x8000 minus one, 0x7fff maximum
// - Loading either operand register starts a new product
// - MAC loads both operands, accumulates previous product
// - ALU operand is full accumulator or product register
// - 32-bit double precision add and subtract
// - Accumulator bit ops, shifts, toggles and saturation
// - Moves between memory, control and core registers
// - Two address generators, two addresses per cycle
// - Six pointers: increment, decrement, offset, two modulo
// - Low memory one cycle, full address two cycles
// - Single instruction repeat and hardware loop counters
// - Calls, conditional and unconditional branches change PC
// - Pointer configuration registers steer address generation
// - Every location reachable, indirect and circular modes
// - Direct operand carries 8-bit address, bank selected
// - Loop counter loads 8-bit unsigned immediate
// - Repeat count n executes next instruction n+1 times
package dsp_pkg;
   // ==========================================================
   // Constants
   localparam logic [15:0] PC_RST   = 16'h0000;
   localparam logic [15:0] WORD_RST = 16'h0000;
   localparam logic [39:0] ACC_RST  = 40'h00_0000_0000;
   localparam logic [39:0] SAT_POS  = 40'h00_7fff_ffff;
   localparam logic [39:0] SAT_NEG  = 40'hff_8000_0000;
   localparam logic [15:0] FRAC_MIN = 16'h8000;
   localparam logic [15:0] FRAC_MAX = 16'h7fff;
   localparam logic [31:0] PROD_MAX = 32'h7fff_ffff;
   localparam logic [8:0]  REP_RST  = 9'h000;
   localparam logic [1:0]  SP_RST   = 2'h0;

   // ==========================================================
   // Encodings
   typedef enum logic [3:0] {OP_NOP = 4'b0000, OP_MAC = 4'b0001, OP_ALU = 4'b0010,
      OP_LDD = 4'b0011, OP_STD = 4'b0100, OP_LDLC = 4'b0101, OP_REP = 4'b0110,
      OP_BRA = 4'b0111, OP_RET = 4'b1000, OP_LDP = 4'b1001, OP_LDL = 4'b1010,
      OP_MOV = 4'b1011, OP_LDI = 4'b1100, OP_STI = 4'b1101} op_t;
   typedef enum logic [3:0] {FN_ADD = 4'b0000, FN_SUB = 4'b0001, FN_SHA = 4'b0010,
      FN_SHL = 4'b0011, FN_SAT = 4'b0100, FN_TGL = 4'b0101, FN_SET = 4'b0110,
      FN_CLR = 4'b0111, FN_NORM = 4'b1000, FN_DNRM = 4'b1001,
      FN_ZERO = 4'b1010} alu_t;
   typedef enum logic [3:0] {RG_ACC_EXT = 4'b0000, RG_ACC_HIGH = 4'b0001,
      RG_ACC_LOW = 4'b0010, RG_PROD_HIGH = 4'b0011, RG_PROD_LOW = 4'b0100,
      RG_X = 4'b0101, RG_Y = 4'b0110, RG_LOOP0 = 4'b0111, RG_LOOP1 = 4'b1000,
      RG_EXP = 4'b1001} reg_t;
   typedef enum logic [2:0] {PM_INC = 3'b000, PM_DEC = 3'b001, PM_OFS = 3'b010,
      PM_MODU = 3'b011, PM_MODD = 3'b100} pmode_t;
   typedef enum logic [2:0] {CD_ALW = 3'b000, CD_ZERO = 3'b001, CD_NEG = 3'b010,
      CD_LOOP0 = 3'b100, CD_LOOP1 = 3'b101} cond_t;

   typedef struct packed {op_t op; logic [11:0] arg;} insn_t;
   typedef struct packed {insn_t ir; logic [15:0] pc; logic v;} dslot_t;
   typedef struct packed {insn_t ir; logic [15:0] imm; logic [15:0] pc; logic v;} eslot_t;
   typedef struct packed {logic we; logic [15:0] addr; logic [15:0] data;} memwr_t;
   typedef struct packed {pmode_t mode; logic [4:0] rsv; logic [7:0] len;} pcfg_t;

   // ==========================================================
   // Helpers
   function automatic logic two_word(input op_t op);
      return op == OP_BRA || op == OP_LDP || op == OP_LDL;
   endfunction : two_word

   // Pointer number from group (0 first memory, 1 second) and index
   function automatic logic [2:0] pidx(input logic g, input logic [1:0] f);
      logic [1:0] k;
      k = (f == 2'h3) ? 2'h0 : f;
      return g ? 3'(k) + 3'h3 : 3'(k);
   endfunction : pidx

   // Post-modify; modulo window is the low byte, length len+1
   function automatic logic [15:0] ptr_step(input logic [15:0] p, input pcfg_t c);
      case (c.mode)
         PM_DEC:  return p - 16'h0001;
         PM_OFS:  return p + {8'h00, c.len};
         PM_MODU: return (p[7:0] == c.len) ? {p[15:8], 8'h00} : p + 16'h0001;
         PM_MODD: return (p[7:0] == 8'h00) ? {p[15:8], c.len} : p - 16'h0001;
         default: return p + 16'h0001;
      endcase
   endfunction : ptr_step

   // Fractional product, -1 times -1 saturates
   function automatic logic [31:0] fmul(input logic [15:0] a, input logic [15:0] b);
      logic [31:0] p;
      p = $signed({{16{a[15]}}, a}) * $signed({{16{b[15]}}, b});
      if (a == FRAC_MIN && b == FRAC_MIN)
         return PROD_MAX;
      return {p[30:0], 1'b0};
   endfunction : fmul

   function automatic logic [39:0] sx(input logic [31:0] p);
      return {{8{p[31]}}, p};
   endfunction : sx

   // Signed amount: positive shifts left
   function automatic logic [39:0] bshift(input logic [39:0] a, input logic [5:0] n,
                                          input logic arith);
      logic [5:0] m;
      m = n[5] ? 6'(-n) : n;
      if (!n[5])
         return a << m;
      if (arith)
         return 40'($signed(a) >>> m);
      return a >> m;
   endfunction : bshift

   // Redundant sign bits
   function automatic logic [5:0] clb(input logic [39:0] a);
      clb = 6'h00;
      for (int i = 38; i >= 0; i--)
         if (a[i] == a[39] && clb == 6'(38 - i))
            clb = 6'(39 - i);
   endfunction : clb
endpackage : dsp_pkg

//--- dsp_core.sv
/* Fixed-point DSP core: three-stage sequencer, MAC, 40-bit ALU and
   two address generators. Assumes program and data memories that read
   combinationally from the address outputs and write on the clock edge. */
`timescale 1ns/100ps
module dsp_core (
   input  wire logic            core_clk,
   input  wire logic            ce,
   input  wire logic            resetn,
   output logic [15:0]          pm_addr,
   input  wire logic [15:0]     pm_rdata,
   output logic [15:0]          x_addr,
   input  wire logic [15:0]     x_rdata,
   output dsp_pkg::memwr_t      x_wr,
   output logic [15:0]          y_addr,
   input  wire logic [15:0]     y_rdata,
   output dsp_pkg::memwr_t      y_wr,
   output logic [39:0]          acc_value
);
   // ==========================================================
   // Reset release
   logic [1:0] rst_sync_r;
   logic       rst_n;
   always_ff @(posedge core_clk or negedge resetn)
      if (!resetn)
         rst_sync_r <= 2'h0;
      else
         rst_sync_r <= {rst_sync_r[0], 1'b1};
   assign rst_n = rst_sync_r[1];

   // ==========================================================
   // State
   logic [15:0]      pc_r, pc_nxt, xa_r, xa_nxt, ya_r, ya_nxt;
   dsp_pkg::dslot_t  dec_r, dec_nxt, fw;
   dsp_pkg::eslot_t  exe_r, exe_nxt;
   logic [8:0]       rep_r, rep_nxt;
   logic [15:0]      ptr_r [6];
   logic [15:0]      ptr_nxt [6];
   dsp_pkg::pcfg_t   cfg_r [6];
   dsp_pkg::pcfg_t   cfg_nxt [6];
   logic [15:0]      stk_r [4];
   logic [15:0]      stk_nxt [4];
   logic [1:0]       sp_r, sp_nxt;
   logic [39:0]      acc_r, acc_nxt;
   logic [31:0]      prod_r, prod_nxt;
   logic [15:0]      x_r, x_nxt, y_r, y_nxt;
   logic [5:0]       exp_r, exp_nxt;
   logic [7:0]       lc_r [2];
   logic [7:0]       lc_nxt [2];
   dsp_pkg::memwr_t  xw_r, xw_nxt, yw_r, yw_nxt;
   logic             take, iss;
   logic [15:0]      target;
   logic [11:0]      darg, earg;

   assign darg = dec_r.ir.arg;
   assign earg = exe_r.ir.arg;
   assign fw = '{ir: dsp_pkg::insn_t'(pm_rdata), pc: pc_r, v: 1'b1};

   // Core register read port
   function automatic logic [15:0] rd16(input dsp_pkg::reg_t s);
      case (s)
         dsp_pkg::RG_ACC_EXT:   return {{8{acc_r[39]}}, acc_r[39:32]};
         dsp_pkg::RG_ACC_HIGH:  return acc_r[31:16];
         dsp_pkg::RG_ACC_LOW:   return acc_r[15:0];
         dsp_pkg::RG_PROD_HIGH: return prod_r[31:16];
         dsp_pkg::RG_PROD_LOW:  return prod_r[15:0];
         dsp_pkg::RG_X:         return x_r;
         dsp_pkg::RG_Y:         return y_r;
         dsp_pkg::RG_LOOP0:     return {8'h00, lc_r[0]};
         dsp_pkg::RG_LOOP1:     return {8'h00, lc_r[1]};
         dsp_pkg::RG_EXP: return {10'h000, exp_r};
         default:         return dsp_pkg::WORD_RST;
      endcase
   endfunction : rd16

   // ==========================================================
   // Fetch and decode: PC, issue, repeat, address generators
   always_comb
   begin
      logic [2:0] pa;
      logic [2:0] pb;
      pa = dsp_pkg::pidx(1'b0, darg[5:4]);
      pb = dsp_pkg::pidx(1'b1, darg[1:0]);
      pc_nxt = pc_r;
      dec_nxt = dec_r;
      exe_nxt = exe_r;
      exe_nxt.v = 1'b0;
      rep_nxt = rep_r;
      xa_nxt = xa_r;
      ya_nxt = ya_r;
      ptr_nxt = ptr_r;
      cfg_nxt = cfg_r;
      iss = 1'b0;
      if (take)
      begin
         pc_nxt = target;
         dec_nxt.v = 1'b0;
         rep_nxt = dsp_pkg::REP_RST;
      end
      else if (!dec_r.v)
      begin
         dec_nxt = fw;
         pc_nxt = pc_r + 16'h0001;
      end
      else if (dec_r.ir.op == dsp_pkg::OP_REP)
      begin
         rep_nxt = darg[8:0];
         dec_nxt = fw;
         pc_nxt = pc_r + 16'h0001;
      end
      else
      begin
         iss = 1'b1;
         exe_nxt = '{ir: dec_r.ir, imm: pm_rdata, pc: dec_r.pc, v: 1'b1};
         if (dsp_pkg::two_word(dec_r.ir.op))
         begin
            dec_nxt.v = 1'b0;
            pc_nxt = pc_r + 16'h0001;
         end
         else if (rep_r != dsp_pkg::REP_RST)
            rep_nxt = rep_r - 9'h001;
         else
         begin
            dec_nxt = fw;
            pc_nxt = pc_r + 16'h0001;
         end
         case (dec_r.ir.op)
            dsp_pkg::OP_MAC:
            begin
               xa_nxt = ptr_r[pa];
               ya_nxt = ptr_r[pb];
               ptr_nxt[pa] = dsp_pkg::ptr_step(ptr_r[pa], cfg_r[pa]);
               ptr_nxt[pb] = dsp_pkg::ptr_step(ptr_r[pb], cfg_r[pb]);
            end
            dsp_pkg::OP_LDD, dsp_pkg::OP_STD:
            begin
               xa_nxt = {8'h00, darg[7:0]};
               ya_nxt = {8'h00, darg[7:0]};
            end
            dsp_pkg::OP_LDL:
            begin
               xa_nxt = pm_rdata;
               ya_nxt = pm_rdata;
            end
            dsp_pkg::OP_LDI, dsp_pkg::OP_STI:
            begin
               pa = dsp_pkg::pidx(darg[2], darg[1:0]);
               xa_nxt = ptr_r[pa];
               ya_nxt = ptr_r[pa];
               ptr_nxt[pa] = dsp_pkg::ptr_step(ptr_r[pa], cfg_r[pa]);
            end
            default: ;
         endcase
      end
      // Pointer or configuration load wins over a same-cycle post-modify
      if (exe_r.v && exe_r.ir.op == dsp_pkg::OP_LDP)
      begin
         pb = dsp_pkg::pidx(earg[2], earg[1:0]);
         if (earg[4])
            cfg_nxt[pb] = dsp_pkg::pcfg_t'(exe_r.imm);
         else
            ptr_nxt[pb] = exe_r.imm;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pc_r <= dsp_pkg::PC_RST;
         dec_r <= '0;
         exe_r <= '0;
         rep_r <= dsp_pkg::REP_RST;
         xa_r <= dsp_pkg::WORD_RST;
         ya_r <= dsp_pkg::WORD_RST;
         ptr_r <= '{default: dsp_pkg::WORD_RST};
         cfg_r <= '{default: '0};
      end
      else if (ce)
      begin
         pc_r <= pc_nxt;
         dec_r <= dec_nxt;
         exe_r <= exe_nxt;
         rep_r <= rep_nxt;
         xa_r <= xa_nxt;
         ya_r <= ya_nxt;
         ptr_r <= ptr_nxt;
         cfg_r <= cfg_nxt;
      end
   end

   // ==========================================================
   // Execute: MAC, ALU, register moves, stores, flow control
   always_comb
   begin
      logic              wen;
      logic              ld;
      dsp_pkg::reg_t     ws;
      logic [15:0]       wv;
      logic [39:0]       opnd;
      logic [39:0]       bm;
      wen = 1'b0;
      ld = 1'b0;
      ws = dsp_pkg::reg_t'(earg[7:4]);
      wv = rd16(dsp_pkg::reg_t'(earg[3:0]));
      opnd = earg[7] ? acc_r : dsp_pkg::sx(prod_r);
      bm = 40'h00_0000_0001 << earg[5:0];
      acc_nxt = acc_r;
      prod_nxt = prod_r;
      x_nxt = x_r;
      y_nxt = y_r;
      exp_nxt = exp_r;
      lc_nxt = lc_r;
      stk_nxt = stk_r;
      sp_nxt = sp_r;
      xw_nxt = '{we: 1'b0, addr: xa_r, data: rd16(dsp_pkg::reg_t'({1'b0, earg[10:8]}))};
      yw_nxt = xw_nxt;
      yw_nxt.addr = ya_r;
      take = 1'b0;
      target = exe_r.imm;
      if (exe_r.v)
         case (exe_r.ir.op)
            dsp_pkg::OP_MAC:
            begin
               if (earg[11])
                  acc_nxt = earg[10] ? acc_r - dsp_pkg::sx(prod_r)
                                     : acc_r + dsp_pkg::sx(prod_r);
               x_nxt = x_rdata;
               y_nxt = y_rdata;
               ld = 1'b1;
            end
            dsp_pkg::OP_ALU:
               case (dsp_pkg::alu_t'(earg[11:8]))
                  dsp_pkg::FN_ADD:  acc_nxt = acc_r + opnd;
                  dsp_pkg::FN_SUB:  acc_nxt = acc_r - opnd;
                  dsp_pkg::FN_SHA:  acc_nxt = dsp_pkg::bshift(acc_r, earg[5:0], 1'b1);
                  dsp_pkg::FN_SHL:  acc_nxt = dsp_pkg::bshift(acc_r, earg[5:0], 1'b0);
                  dsp_pkg::FN_SAT:
                     if (acc_r[39:31] != {9{acc_r[39]}})
                        acc_nxt = acc_r[39] ? dsp_pkg::SAT_NEG : dsp_pkg::SAT_POS;
                  dsp_pkg::FN_TGL:  acc_nxt = acc_r ^ bm;
                  dsp_pkg::FN_SET:  acc_nxt = acc_r | bm;
                  dsp_pkg::FN_CLR:  acc_nxt = acc_r & ~bm;
                  dsp_pkg::FN_NORM:
                  begin
                     exp_nxt = dsp_pkg::clb(acc_r);
                     acc_nxt = acc_r << dsp_pkg::clb(acc_r);
                  end
                  dsp_pkg::FN_DNRM: acc_nxt = 40'($signed(acc_r) >>> exp_r);
                  dsp_pkg::FN_ZERO: acc_nxt = dsp_pkg::ACC_RST;
                  default: ;
               endcase
            dsp_pkg::OP_LDD, dsp_pkg::OP_LDL:
            begin
               wen = 1'b1;
               ws = dsp_pkg::reg_t'({1'b0, earg[10:8]});
               wv = earg[11] ? y_rdata : x_rdata;
            end
            dsp_pkg::OP_LDI:
            begin
               wen = 1'b1;
               ws = dsp_pkg::reg_t'(earg[11:8]);
               wv = earg[2] ? y_rdata : x_rdata;
            end
            dsp_pkg::OP_STD:
            begin
               xw_nxt.we = !earg[11];
               yw_nxt.we = earg[11];
            end
            dsp_pkg::OP_STI:
            begin
               xw_nxt.data = rd16(dsp_pkg::reg_t'(earg[11:8]));
               yw_nxt.data = xw_nxt.data;
               xw_nxt.we = !earg[2];
               yw_nxt.we = earg[2];
            end
            dsp_pkg::OP_MOV:  wen = 1'b1;
            dsp_pkg::OP_LDLC: lc_nxt[earg[8]] = earg[7:0];
            dsp_pkg::OP_BRA:
            begin
               case (dsp_pkg::cond_t'(earg[11:9]))
                  dsp_pkg::CD_ALW:  take = 1'b1;
                  dsp_pkg::CD_ZERO: take = acc_r == dsp_pkg::ACC_RST;
                  dsp_pkg::CD_NEG:  take = acc_r[39];
                  dsp_pkg::CD_LOOP0, dsp_pkg::CD_LOOP1:
                  begin
                     take = lc_r[earg[9]] != 8'h00;
                     if (take)
                        lc_nxt[earg[9]] = lc_r[earg[9]] - 8'h01;
                  end
                  default: ;
               endcase
               if (take && earg[8])
               begin
                  stk_nxt[sp_r] = exe_r.pc + 16'h0002;
                  sp_nxt = sp_r + 2'h1;
               end
            end
            dsp_pkg::OP_RET:
            begin
               take = 1'b1;
               sp_nxt = sp_r - 2'h1;
               target = stk_r[sp_nxt];
            end
            default: ;
         endcase
      // Register destination
      if (wen)
         case (ws)
            dsp_pkg::RG_ACC_EXT:   acc_nxt[39:32] = wv[7:0];
            dsp_pkg::RG_ACC_HIGH:  acc_nxt[31:16] = wv;
            dsp_pkg::RG_ACC_LOW:   acc_nxt[15:0] = wv;
            dsp_pkg::RG_PROD_HIGH: prod_nxt[31:16] = wv;
            dsp_pkg::RG_PROD_LOW:  prod_nxt[15:0] = wv;
            dsp_pkg::RG_X:         {ld, x_nxt} = {1'b1, wv};
            dsp_pkg::RG_Y:         {ld, y_nxt} = {1'b1, wv};
            dsp_pkg::RG_LOOP0:     lc_nxt[0] = wv[7:0];
            dsp_pkg::RG_LOOP1:     lc_nxt[1] = wv[7:0];
            dsp_pkg::RG_EXP: exp_nxt = wv[5:0];
            default: ;
         endcase
      if (ld)
         prod_nxt = dsp_pkg::fmul(x_nxt, y_nxt);
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         acc_r <= dsp_pkg::ACC_RST;
         prod_r <= '0;
         x_r <= dsp_pkg::WORD_RST;
         y_r <= dsp_pkg::WORD_RST;
         exp_r <= '0;
         lc_r <= '{default: 8'h00};
         stk_r <= '{default: dsp_pkg::WORD_RST};
         sp_r <= dsp_pkg::SP_RST;
         xw_r <= '0;
         yw_r <= '0;
      end
      else if (ce)
      begin
         acc_r <= acc_nxt;
         prod_r <= prod_nxt;
         x_r <= x_nxt;
         y_r <= y_nxt;
         exp_r <= exp_nxt;
         lc_r <= lc_nxt;
         stk_r <= stk_nxt;
         sp_r <= sp_nxt;
         xw_r <= xw_nxt;
         yw_r <= yw_nxt;
      end
   end

   // Outputs
   assign pm_addr = pc_r;
   assign x_addr = xa_r;
   assign y_addr = ya_r;
   assign x_wr = xw_r;
   assign y_wr = yw_r;
   assign acc_value = acc_r;

   // ==========================================================
   // Checks
   logic [39:0] acc_sum_w;
   logic [15:0] mac_xa_w, mac_ya_w, dpc_w;
   logic        mac_add_w, dec_mac_w;
   assign acc_sum_w = acc_r + dsp_pkg::sx(prod_r);
   assign mac_xa_w = ptr_r[dsp_pkg::pidx(1'b0, darg[5:4])];
   assign mac_ya_w = ptr_r[dsp_pkg::pidx(1'b1, darg[1:0])];
   assign dpc_w = dec_r.pc;
   assign mac_add_w = exe_r.v && exe_r.ir.op == dsp_pkg::OP_MAC && earg[11] && !earg[10];
   assign dec_mac_w = iss && dec_r.ir.op == dsp_pkg::OP_MAC;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   mac_accum_a: assert property (ce && mac_add_w |=> acc_r == $past(acc_sum_w))
      else $error("MAC did not add previous product");
   prod_load_a: assert property (ce && exe_r.v && exe_r.ir.op == dsp_pkg::OP_MAC
      |=> prod_r == dsp_pkg::fmul(x_r, y_r)) else $error("Product not from new operands");
   pipe_order_a: assert property (ce && iss && !take
      |=> exe_r.v && exe_r.pc == $past(dpc_w)) else $error("Execute not fed by decode");
   branch_flush_a: assert property (ce && take
      |=> !exe_r.v && !dec_r.v && pc_r == $past(target)) else $error("Branch did not flush");
   dual_addr_a: assert property (ce && dec_mac_w && !take
      |=> xa_r == $past(mac_xa_w) && ya_r == $past(mac_ya_w)) else $error("MAC addresses wrong");
   direct_addr_a: assert property (ce && iss && !take && dec_r.ir.op == dsp_pkg::OP_LDD
      |=> xa_r[15:8] == 8'h00 && xa_r[7:0] == $past(darg[7:0])) else $error("Direct address");
   rep_count_a: assert property (ce && !take && dec_r.v && dec_r.ir.op == dsp_pkg::OP_REP
      |=> rep_r == $past(darg[8:0])) else $error("Repeat count not loaded");
   loop_load_a: assert property (ce && exe_r.v && exe_r.ir.op == dsp_pkg::OP_LDLC && !earg[8]
      |=> lc_r[0] == $past(earg[7:0])) else $error("Loop counter load");
   two_word_a: assert property (ce && iss && !take && dsp_pkg::two_word(dec_r.ir.op)
      |=> !dec_r.v) else $error("Second word not consumed");
   sat_range_a: assert property (ce && exe_r.v && exe_r.ir.op == dsp_pkg::OP_ALU
      && earg[11:8] == 4'h4 |=> acc_r[39:31] == {9{acc_r[39]}}) else $error("Saturation failed");

   mac_run_c: cover property (ce && mac_add_w ##1 ce && mac_add_w);
   branch_c: cover property (ce && take && earg[8]);
   rep_run_c: cover property (ce && iss && rep_r != dsp_pkg::REP_RST);
endmodule : dsp_core

//--- mem_model.sv
/* Program memory and the two data memories seen by the DSP core.
   Assumes the core reads combinationally and writes on a we pulse. */
`timescale 1ns/100ps
module mem_model (
   input  wire logic            core_clk,
   input  wire logic [15:0]     pm_addr,
   output logic [15:0]          pm_rdata,
   input  wire logic [15:0]     x_addr,
   output logic [15:0]          x_rdata,
   input  wire dsp_pkg::memwr_t x_wr,
   input  wire logic [15:0]     y_addr,
   output logic [15:0]          y_rdata,
   input  wire dsp_pkg::memwr_t y_wr
);
   // ==========================================================
   // Storage, loaded by the bench
   logic [15:0] pm [0:255];
   logic [15:0] xm [0:255];
   logic [15:0] ym [0:255];

   // Three independent reads in the same cycle
   assign pm_rdata = pm[pm_addr[7:0]];
   assign x_rdata  = xm[x_addr[7:0]];
   assign y_rdata  = ym[y_addr[7:0]];

   // Writes land at the edge where we is high
   always @(posedge core_clk)
   begin
      if (x_wr.we)
         xm[x_wr.addr[7:0]] <= x_wr.data;
      if (y_wr.we)
         ym[y_wr.addr[7:0]] <= y_wr.data;
   end
endmodule : mem_model

//--- tb.sv
/* Self-checking bench for the DSP core: runs short programs and
   judges the accumulator, data memories and address outputs. */
`timescale 1ns/100ps
module tb;
   logic            core_clk = 1'b0;
   logic            ce       = 1'b1;
   logic            resetn   = 1'b0;
   logic [15:0]     pm_addr, pm_rdata, x_addr, x_rdata, y_addr, y_rdata;
   dsp_pkg::memwr_t x_wr, y_wr;
   logic [39:0]     acc_value;
   int              n_errors   = 0;
   int              n_compared = 0;

   // ==========================================================
   // Clock, design and memories
   always #10 core_clk = ~core_clk;

   dsp_core dsp_core_i (.core_clk(core_clk), .ce(ce), .resetn(resetn),
      .pm_addr(pm_addr), .pm_rdata(pm_rdata), .x_addr(x_addr), .x_rdata(x_rdata),
      .x_wr(x_wr), .y_addr(y_addr), .y_rdata(y_rdata), .y_wr(y_wr),
      .acc_value(acc_value));
   mem_model mem_model_i (.core_clk(core_clk), .pm_addr(pm_addr), .pm_rdata(pm_rdata),
      .x_addr(x_addr), .x_rdata(x_rdata), .x_wr(x_wr), .y_addr(y_addr),
      .y_rdata(y_rdata), .y_wr(y_wr));

   // ==========================================================
   // Shared tasks
   task automatic check(input string what, input logic [39:0] seen,
                        input logic [39:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask : check

   // Reset the core and clear all memories to zero words
   task automatic restart;
      @(negedge core_clk);
      resetn = 1'b0;
      for (int i = 0; i < 256; i++)
      begin
         mem_model_i.pm[i] = 16'h0000;
         mem_model_i.xm[i] = 16'h0000;
         mem_model_i.ym[i] = 16'h0000;
      end
      repeat (2) @(negedge core_clk);
      check("acc in reset", acc_value, 40'h00_0000_0000);
      check("store pulse in reset", {39'h0, x_wr.we | y_wr.we}, 40'h0);
   endtask : restart

   task automatic put(input logic [7:0] at, input logic [15:0] w[$]);
      foreach (w[i])
         mem_model_i.pm[at + 8'(i)] = w[i];
   endtask : put

   task automatic run(input int n);
      resetn = 1'b1;
      repeat (n) @(negedge core_clk);
   endtask : run

   // ==========================================================
   // Scenarios
   // MACs: 0.5*0.5, then -1*-1 saturating, then 0x7fff*-1; sat, add/sub product
   task automatic mac_chain;
      restart;
      mem_model_i.xm[0] = 16'h4000;
      mem_model_i.xm[1] = 16'h8000;
      mem_model_i.xm[2] = 16'h7fff;
      mem_model_i.ym[0] = 16'h4000;
      mem_model_i.ym[1] = 16'h8000;
      mem_model_i.ym[2] = 16'h8000;
      put(8'h00, '{16'h1000, 16'h1800, 16'h1800, 16'h2480, 16'h2000, 16'h2100, 16'h2100});
      run(30);
      // 0x9fffffff sat to 0x7fffffff, +P(0x80010000) = 0xffff, minus P twice
      check("acc after mac chain", acc_value, 40'h00_fffe_ffff);
      check("x pointer", {24'h0, x_addr}, 40'h2);
      check("y pointer", {24'h0, y_addr}, 40'h2);
   endtask : mac_chain

   // Load 1, repeat shift three times, call shifts once, return skips stray shift
   task automatic call_repeat;
      restart;
      mem_model_i.xm[5] = 16'h0001;
      put(8'h00, '{16'h3205, 16'h6002, 16'h2381, 16'h7100, 16'h0020, 16'h4a10});
      put(8'h20, '{16'h2381, 16'h8000, 16'h2381});
      run(40);
      check("acc after call", acc_value, 40'h00_0000_0010);
      check("stored word", {24'h0, mem_model_i.ym[16]}, 40'h10);
   endtask : call_repeat

   // Frozen start, then loop counter 2 runs the shift body three times
   task automatic hw_loop;
      restart;
      mem_model_i.xm[5] = 16'h0001;
      put(8'h00, '{16'h3205, 16'h5002, 16'h2381, 16'h7800, 16'h0002, 16'h7200,
                   16'h0030, 16'h4210});
      put(8'h30, '{16'h2381});
      ce = 1'b0;
      run(10);
      check("pc while frozen", {24'h0, pm_addr}, 40'h0);
      ce = 1'b1;
      run(40);
      check("acc after loop", acc_value, 40'h00_0000_0008);
      check("stored word", {24'h0, mem_model_i.xm[16]}, 40'h8);
   endtask : hw_loop

   // Pointer 0 modulo window of two, pointer 4 at 8; indirect loads build
   // 0x0001_1234, store wraps to word 0, acc doubled by itself, stored to
   // second memory word 8, then high half loaded from second memory word 9
   task automatic indirect_mod;
      restart;
      mem_model_i.xm[0] = 16'h0001;
      mem_model_i.xm[1] = 16'h1234;
      mem_model_i.ym[9] = 16'h0abc;
      put(8'h00, '{16'h9010, 16'h6001, 16'h9005, 16'h0008, 16'hc100, 16'hc200,
                   16'hd200, 16'h2080, 16'hd205, 16'ha900, 16'h0009});
      run(30);
      check("acc after indirect", acc_value, 40'h00_0abc_2468);
      check("wrapped store", {24'h0, mem_model_i.xm[0]}, 40'h1234);
      check("indirect store", {24'h0, mem_model_i.ym[8]}, 40'h2468);
      check("long address", {24'h0, y_addr}, 40'h9);
   endtask : indirect_mod

   // ==========================================================
   // Verdict and watchdog
   task automatic final_report;
      $display("comparisons %0d, mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : final_report

   initial
   begin
      repeat (12) @(negedge core_clk);
      mac_chain;
      call_repeat;
      indirect_mod;
      hw_loop;
      final_report;
   end

   initial
   begin
      repeat (3000) @(posedge core_clk);
      n_errors++;
      final_report;
   end
endmodule : tb
